// ===== dv/app_layer_bus_partner.sv
// Network master and host processor byte-bus model
`timescale 1ns/1ps
`default_nettype none
module app_layer_bus_partner (
    // Clock
    input wire logic clk,
    // Network master
    output logic [11:0] net_addr,
    output logic net_wr,
    output logic net_rd,
    output logic [7:0] net_wdata,
    input wire logic [7:0] net_rdata,
    // Host processor
    output logic [11:0] host_addr,
    output logic host_wr,
    output logic host_rd,
    output logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata
);
    // Both buses idle at time zero
    initial begin
        {net_wr, net_rd, host_wr, host_rd} = 4'h0;
        {net_addr, host_addr, net_wdata, host_wdata} = 40'h0;
    end

    // One byte access, h picks the host; on release strobes drop to 0, address and data turn inverted
    task automatic acc(input logic h, input logic w, input logic [11:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clk);
        {net_wr, net_rd, host_wr, host_rd} <= {w & ~h, ~w & ~h, w & h, ~w & h};
        {net_addr, host_addr, net_wdata, host_wdata} <= {a, a, d, d};
        @(posedge clk);
        {net_wr, net_rd, host_wr, host_rd} <= 4'h0;
        {net_addr, host_addr, net_wdata, host_wdata} <= {~a, ~a, ~d, ~d};
        @(posedge clk);
        q = h ? host_rdata : net_rdata;
    endtask
endmodule
`default_nettype wire

// ===== dv/app_layer_state_registers_monitor.sv
// Port checker of the application-layer register group
`timescale 1ns/1ps
`default_nettype none
module app_layer_state_registers_monitor
    import app_layer_state_pkg::*;
(
    // Clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic cfg_load,
    input wire logic [7:0] cfg_bits,
    input wire logic ack_by_write,
    // Network side
    input wire logic [11:0] net_addr,
    input wire logic net_wr,
    input wire logic net_rd,
    input wire logic [7:0] net_rdata,
    // Host side
    input wire logic [11:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    // Watched outputs
    input wire logic host_event_state_req,
    input wire logic net_event_state_rep,
    input wire logic [3:0] run_led_code,
    input wire logic [3:0] enh_link_en,
    input wire logic emulation_on
);
    // Single domain, reset masks every check
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Decodes shared by the checks
    wire logic host_req_hit = host_addr[11:1] == ADDR_STATE_REQ_LO[11:1];
    wire logic net_req_wr = net_wr && net_addr == ADDR_STATE_REQ_LO;

    // Checks tied to port causes
    a_reset_outputs_idle: assert property ($rose(rst_n) |-> !host_event_state_req
        && !net_event_state_rep && run_led_code == LED_OFF && enh_link_en == 4'h0 && !emulation_on)
        else $error("outputs not idle after reset");
    a_req_event_set: assert property (ce && net_req_wr && !emulation_on && !host_event_state_req
        |=> host_event_state_req) else $error("mailbox write raised no event");
    a_read_ack_clear: assert property (ce && host_rd && !ack_by_write && host_req_hit && !net_req_wr
        |=> !host_event_state_req) else $error("host read left event set");
    a_write_ack_clear: assert property (ce && host_wr && ack_by_write && host_req_hit && !net_req_wr
        |=> !host_event_state_req) else $error("host write left event set");
    a_report_read_clear: assert property (ce && net_rd && net_addr[11:1] == ADDR_STATE_REP_LO[11:1]
        && !host_wr && !net_wr && !$past(net_wr) |=> !net_event_state_rep) else $error("report event kept");
    a_run_read_live: assert property (ce && net_rd && net_addr == ADDR_RUN_OVR
        |=> net_rdata[3:0] == $past(run_led_code) && net_rdata[7:5] == 3'h0) else $error("stale override read");
    a_ifsel_legal: assert property (ce && net_rd && net_addr == ADDR_IFSEL
        |=> net_rdata == IFSEL_NONE || net_rdata == IFSEL_SERIAL) else $error("bad interface select");
    a_enh_all_ports: assert property (ce && cfg_load && cfg_bits[1]
        |-> ##[1:2] enh_link_en == 4'hF) else $error("all-port enable ignored");
    a_run_override: assert property (ce && host_wr && host_addr == ADDR_RUN_OVR && host_wdata[4] && !net_wr
        |-> ##2 run_led_code == $past(host_wdata[3:0], 2)) else $error("override code not driven");
endmodule

bind app_layer_state_registers app_layer_state_registers_monitor u_app_layer_state_registers_monitor (.*);
`default_nettype wire

// ===== dv/app_layer_state_registers_tb_top.sv
// Self-checking bench of the register group
`timescale 1ns/1ps
`default_nettype none
module app_layer_state_registers_tb_top import app_layer_state_pkg::*; ;
    // Stimulus, wires and counters
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
    logic cfg_load = 1'b0, ack_by_write = 1'b0, new_error = 1'b0;
    logic [7:0] cfg_ifsel = 8'h00, cfg_bits = 8'h00;
    logic [3:0] err_auto_code = 4'h0;
    wire logic [11:0] net_addr, host_addr;
    wire logic net_wr, net_rd, host_wr, host_rd, host_event_state_req, net_event_state_rep;
    wire logic sync_out_en, latch_in_en, emulation_on;
    wire logic [7:0] net_wdata, host_wdata, net_rdata, host_rdata;
    wire logic [3:0] run_led_code, err_led_code, enh_link_en;
    int fail_count = 0, checked = 0, cycles = 0;

    app_layer_state_registers u_app_layer_state_registers (.*);
    app_layer_bus_partner u_app_layer_bus_partner (.*);

    // 125 MHz clock
    always #4 clk = ~clk;

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // Verdict and end of run
    task automatic report_and_stop();
        if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Bus helpers, h selects the host side
    task automatic rd(input logic h, input logic [11:0] a, output logic [7:0] q);
        u_app_layer_bus_partner.acc(h, 1'b0, a, 8'h00, q);
    endtask
    task automatic wr(input logic h, input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_app_layer_bus_partner.acc(h, 1'b1, a, d, q);
    endtask
    task automatic rchk(input logic h, input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] q;
        rd(h, a, q);
        chk(q, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Reset contents and an unmapped read
    task automatic t_reset();
        rchk(1'b1, ADDR_STATE_REP_LO, 8'h01);
        rchk(1'b1, ADDR_STATE_REQ_LO, 8'h00);
        rchk(1'b0, ADDR_IFSEL, IFSEL_NONE);
        rchk(1'b0, ADDR_CFG, 8'h00);
        rchk(1'b1, 12'h200, 8'h00);
    endtask

    // Every state code through the empty mailbox
    task automatic t_codes();
        logic [3:0] code [5] = '{ST_INIT, ST_PRE_OP, ST_BOOT, ST_SAFE_OP, ST_OP};
        for (int i = 0; i < 5; i++) begin
            wr(1'b0, ADDR_STATE_REQ_LO, {4'h0, code[i]});
            chk(8'(host_event_state_req), 8'h01);
            rchk(1'b1, ADDR_STATE_REQ_LO, {4'h0, code[i]});
            chk(8'(host_event_state_req), 8'h00);
        end
    endtask

    // Full mailbox drops writes until a host access
    task automatic t_mailbox();
        wr(1'b0, ADDR_STATE_REQ_LO, 8'h18);
        wr(1'b0, ADDR_STATE_REQ_LO, 8'h02);
        rchk(1'b0, ADDR_STATE_REQ_LO, 8'h18);
        rchk(1'b1, ADDR_STATE_REQ_HI, 8'h00);
        wr(1'b0, ADDR_STATE_REQ_LO, 8'h04);
        rchk(1'b0, ADDR_STATE_REQ_LO, 8'h04);
        wr(1'b1, ADDR_STATE_REQ_LO, 8'h1F);
        chk(8'(host_event_state_req), 8'h01);
        rchk(1'b1, ADDR_STATE_REQ_LO, 8'h04);
    endtask

    // Write acknowledge clears the event, value discarded
    task automatic t_ack_write();
        @(posedge clk);
        ack_by_write <= 1'b1;
        wr(1'b0, ADDR_STATE_REQ_LO, {4'h0, ST_BOOT});
        chk(8'(host_event_state_req), 8'h01);
        wr(1'b1, ADDR_STATE_REQ_LO, 8'h00);
        chk(8'(host_event_state_req), 8'h00);
        rchk(1'b0, ADDR_STATE_REQ_LO, {4'h0, ST_BOOT});
        ack_by_write <= 1'b0;
    endtask

    // Host-written report and its network event
    task automatic t_report();
        wr(1'b1, ADDR_STATE_REP_LO, 8'h12);
        chk(8'(net_event_state_rep), 8'h01);
        rchk(1'b0, ADDR_STATE_REP_LO, 8'h12);
        chk(8'(net_event_state_rep), 8'h00);
        wr(1'b1, ADDR_STATE_REP_LO, 8'h24);
        rchk(1'b0, ADDR_STATE_REP_HI, 8'h00);
        chk(8'(net_event_state_rep), 8'h00);
        rchk(1'b1, ADDR_STATE_REP_LO, 8'h24);
        wr(1'b1, ADDR_CODE_LO, 8'hA5);
        rchk(1'b0, ADDR_CODE_LO, 8'hA5);
    endtask

    // RUN codes under override, then a report change drops it
    task automatic t_run_led();
        logic [3:0] led [6] = '{LED_OFF, LED_FLASH_ONCE, 4'hC, LED_BLINK, LED_FLICKER, LED_ON};
        logic [7:0] q;
        for (int i = 0; i < 6; i++) begin
            wr(1'b1, ADDR_RUN_OVR, {4'h1, led[i]});
            idle(1);
            chk(8'(run_led_code), 8'(led[i]));
            rchk(1'b0, ADDR_RUN_OVR, {4'h1, led[i]});
        end
        wr(1'b1, ADDR_STATE_REP_LO, {4'h0, ST_SAFE_OP});
        rd(1'b1, ADDR_RUN_OVR, q);
        chk(8'(q[4]), 8'h00);
    endtask

    // New error returns ERR to the automatic code
    task automatic t_err_led();
        @(posedge clk);
        err_auto_code <= 4'h3;
        wr(1'b0, ADDR_ERR_OVR, 8'h1E);
        idle(1);
        chk(8'(err_led_code), 8'h0E);
        new_error <= 1'b1;
        @(posedge clk);
        new_error <= 1'b0;
        idle(2);
        rchk(1'b1, ADDR_ERR_OVR, 8'h03);
    endtask

    // Configuration load pulse
    task automatic load(input logic [7:0] ifsel, input logic [7:0] bits);
        @(posedge clk);
        {cfg_load, cfg_ifsel, cfg_bits} <= {1'b1, ifsel, bits};
        @(posedge clk);
        cfg_load <= 1'b0;
        idle(2);
    endtask

    // Unit enables, select filtering and emulation
    task automatic t_config();
        load(IFSEL_SERIAL, 8'hA4);
        chk(8'({enh_link_en, sync_out_en, latch_in_en}), 8'h2A);
        rchk(1'b0, ADDR_IFSEL, IFSEL_SERIAL);
        load(IFSEL_ONCHIP, 8'h3A);
        chk(8'({enh_link_en, sync_out_en, latch_in_en}), 8'h3D);
        rchk(1'b0, ADDR_IFSEL, IFSEL_NONE);
        wr(1'b0, ADDR_CFG, 8'h01);
        idle(1);
        chk(8'(emulation_on), 8'h01);
        rchk(1'b1, ADDR_CFG, 8'h3B);
        wr(1'b0, ADDR_STATE_REQ_LO, {4'h0, ST_OP});
        wr(1'b0, ADDR_STATE_REQ_LO, {4'h0, ST_PRE_OP});
        rchk(1'b0, ADDR_STATE_REP_LO, {4'h0, ST_PRE_OP});
        wr(1'b1, ADDR_STATE_REP_LO, 8'h01);
        rchk(1'b0, ADDR_STATE_REP_LO, {4'h0, ST_PRE_OP});
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_codes();
        t_mailbox();
        t_ack_write();
        t_report();
        t_run_led();
        t_err_led();
        t_config();
        report_and_stop();
    end
endmodule
`default_nettype wire

// ===== rtl/app_layer_state_registers.sv
// Application-layer state registers, indicator overrides and configuration
// Function
// (R1) Request bits 3:0 carry state code 1,2,3,4 or 8 written by the network.
// (R2) Request bit 4 written 1 acknowledges the error indication in the report.
// (R3) Request bit 4 also reads as identification request, 1 requests, 0 none.
// (R4) Without emulation, request is a mailbox; network rewrites wait for a host access.
// (R5) Host access to either request byte frees the mailbox.
// (R6) Mailbox is empty after reset so the network can write at once.
// (R7) With emulation, network writes always land and copy into the report.
// (R8) Without ack-by-write, host read clears host event bit 0; host writes ignored.
// (R9) With ack-by-write, host write clears host event bit 0; value is discarded.
// (R10) Report bits 3:0 show actual state with the same codes.
// (R11) Report bit 4 flags a failed or locally caused state change.
// (R12) Report bit 5 shows identification value loaded and valid.
// (R13) Host writes report only without emulation; otherwise report mirrors request.
// (R14) Network read of the report clears network event bit 3.
// (R15) RUN code: 0 off, 1..C flash count, D blink, E flicker, F on.
// (R16) Override bit 4 makes the LED follow the written code.
// (R17) Report change to a valid state clears the RUN override enable.
// (R18) Override register reads return the code currently driven on the LED.
// (R19) A new error condition clears the ERR override enable.
// (R20) Interface select: 00 none, 05 serial slave, 80 on-chip; only 05 built; resets 00.
// (R21) Configuration bit 0 selects emulation of the state report.
// (R22) Config bit 1 enables enhanced link on all ports, overriding bits 7:4.
// (R23) Configuration bits 2 and 3 enable sync output and latch input units.
// (R24) Ack-by-write option is bit 0 of the interface information register.
`timescale 1ns/1ps
`default_nettype none
module app_layer_state_registers
    import app_layer_state_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Network-side byte access
    input wire logic [11:0] net_addr,
    input wire logic net_wr,
    input wire logic net_rd,
    input wire logic [7:0] net_wdata,
    output logic [7:0] net_rdata,
    // Host-side byte access
    input wire logic [11:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    // Configuration load from non-volatile storage
    input wire logic cfg_load,
    input wire logic [7:0] cfg_ifsel,
    input wire logic [7:0] cfg_bits,
    input wire logic ack_by_write,
    // Error indicator inputs
    input wire logic new_error,
    input wire logic [3:0] err_auto_code,
    // Events toward the event request registers
    output logic host_event_state_req,
    output logic net_event_state_rep,
    // Indicator codes and unit enables
    output logic [3:0] run_led_code,
    output logic [3:0] err_led_code,
    output logic [3:0] enh_link_en,
    output logic sync_out_en,
    output logic latch_in_en,
    output logic emulation_on
);

    // --------------------------------------------------------------
    // Storage
    // --------------------------------------------------------------
    logic [4:0] state_req;
    logic [5:0] state_rep;
    logic [15:0] status_code;
    logic [4:0] run_ovr;
    logic [4:0] err_ovr;
    logic [7:0] ifsel;
    logic [7:0] cfg;
    mbox_state_t mbox;
    logic err_ind_seen;

    // --------------------------------------------------------------
    // Access decode
    // --------------------------------------------------------------
    logic net_req_wr_lo;
    logic net_req_acc;
    logic net_rep_rd;
    logic host_req_rd;
    logic host_req_wr;
    logic host_req_access;
    logic host_rep_wr;
    logic [5:0] next_state_rep;
    logic rep_changed;
    logic rep_valid;
    logic emul;

    assign emul = cfg[CFG_EMUL_BIT];
    assign net_req_wr_lo = net_wr && (net_addr == ADDR_STATE_REQ_LO);
    // Network write lands when emulating or the mailbox is free
    assign net_req_acc = net_req_wr_lo && (emul || (mbox == MBOX_EMPTY)); // R4 R7
    assign net_rep_rd = net_rd && (net_addr[11:1] == ADDR_STATE_REP_LO[11:1]);
    assign host_req_rd = host_rd && (host_addr[11:1] == ADDR_STATE_REQ_LO[11:1]);
    assign host_req_wr = host_wr && (host_addr[11:1] == ADDR_STATE_REQ_LO[11:1]);
    // Host read or write of either byte frees the mailbox
    assign host_req_access = host_req_rd || host_req_wr; // R5
    // Report writable from the host only while not emulating
    assign host_rep_wr = host_wr && (host_addr == ADDR_STATE_REP_LO) && !emul; // R13

    // --------------------------------------------------------------
    // Next report value and change detection
    // --------------------------------------------------------------
    // Emulation copies the request in; otherwise the host sets it
    always_comb begin
        next_state_rep = state_rep;
        if (emul && net_req_acc) begin
            next_state_rep = {state_rep[IDENT_VALID_BIT], net_wdata[4:0]}; // R7 R13 R21
        end else if (host_rep_wr) begin
            next_state_rep = host_wdata[5:0]; // R10 R11 R12 R21
        end
    end

    // Valid state codes are the five documented ones
    always_comb begin
        unique case (next_state_rep[STATE_MSB:0])
            ST_INIT, ST_PRE_OP, ST_BOOT, ST_SAFE_OP, ST_OP: rep_valid = 1'b1;
            default: rep_valid = 1'b0;
        endcase
    end

    assign rep_changed = (next_state_rep != state_rep);

    // --------------------------------------------------------------
    // State request register
    // --------------------------------------------------------------
    // Holds state code and the acknowledge/identification bit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_req <= RST_STATE_REQ;
        end else if (ce) begin
            if (net_req_acc) begin
                state_req <= net_wdata[4:0]; // R1 R2 R3
            end
        end
    end

    // Mailbox; a network write wins over a host release
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mbox <= MBOX_EMPTY; // R6
        end else if (ce) begin
            if (net_req_acc && !emul) begin
                mbox <= MBOX_FULL; // R4
            end else if (host_req_access || emul) begin
                mbox <= MBOX_EMPTY; // R5
            end
        end
    end

    // Host event bit 0: set on new request, cleared by read or write per ack mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            host_event_state_req <= 1'b0;
        end else if (ce) begin
            if (net_req_acc) begin
                host_event_state_req <= 1'b1;
            end else if (!ack_by_write && host_req_rd) begin
                host_event_state_req <= 1'b0; // R8 R24
            end else if (ack_by_write && host_req_wr) begin
                host_event_state_req <= 1'b0; // R9 R24
            end
        end
    end

    // --------------------------------------------------------------
    // State report register and network event
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_rep <= RST_STATE_REP;
        end else if (ce) begin
            state_rep <= next_state_rep; // R10 R13
        end
    end

    // Network event bit 3: set on report change, cleared by report read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            net_event_state_rep <= 1'b0;
        end else if (ce) begin
            if (rep_changed) begin
                net_event_state_rep <= 1'b1;
            end else if (net_rep_rd) begin
                net_event_state_rep <= 1'b0; // R14
            end
        end
    end

    // Status code: host writes bytes, network only reads
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_code <= RST_STATUS_CODE;
        end else if (ce) begin
            if (host_wr && (host_addr == ADDR_CODE_LO)) begin
                status_code[7:0] <= host_wdata;
            end
            if (host_wr && (host_addr == ADDR_CODE_HI)) begin
                status_code[15:8] <= host_wdata;
            end
        end
    end

    // --------------------------------------------------------------
    // Indicator overrides
    // --------------------------------------------------------------
    logic net_run_wr;
    logic host_run_wr;
    logic net_err_wr;
    logic host_err_wr;
    logic err_rise;

    assign net_run_wr = net_wr && (net_addr == ADDR_RUN_OVR);
    assign host_run_wr = host_wr && (host_addr == ADDR_RUN_OVR);
    assign net_err_wr = net_wr && (net_addr == ADDR_ERR_OVR);
    assign host_err_wr = host_wr && (host_addr == ADDR_ERR_OVR);
    // A fresh error is an external event or the error flag coming up
    assign err_rise = new_error || (next_state_rep[ERR_IND_BIT] && !err_ind_seen);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            err_ind_seen <= 1'b0;
        end else if (ce) begin
            err_ind_seen <= next_state_rep[ERR_IND_BIT];
        end
    end

    // RUN override; a valid report change clears the enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_ovr <= RST_OVR;
        end else if (ce) begin
            if (net_run_wr) begin
                run_ovr <= net_wdata[4:0]; // R16
            end else if (host_run_wr) begin
                run_ovr <= host_wdata[4:0]; // R16
            end
            if (rep_changed && rep_valid) begin
                run_ovr[OVR_EN_BIT] <= 1'b0; // R17
            end
        end
    end

    // ERR override; a new error clears the enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            err_ovr <= RST_OVR;
        end else if (ce) begin
            if (net_err_wr) begin
                err_ovr <= net_wdata[4:0]; // R16
            end else if (host_err_wr) begin
                err_ovr <= host_wdata[4:0]; // R16
            end
            if (err_rise) begin
                err_ovr[OVR_EN_BIT] <= 1'b0; // R19
            end
        end
    end

    // --------------------------------------------------------------
    // Indicator code selection
    // --------------------------------------------------------------
    logic [3:0] run_auto_code;

    // State-derived RUN pattern
    always_comb begin
        unique case (state_rep[STATE_MSB:0])
            ST_PRE_OP: run_auto_code = LED_BLINK;
            ST_BOOT: run_auto_code = LED_FLICKER;
            ST_SAFE_OP: run_auto_code = LED_FLASH_ONCE;
            ST_OP: run_auto_code = LED_ON;
            default: run_auto_code = LED_OFF;
        endcase
    end

    // Registered codes toward the LED drivers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_led_code <= LED_OFF;
            err_led_code <= LED_OFF;
        end else if (ce) begin
            run_led_code <= run_ovr[OVR_EN_BIT] ? run_ovr[3:0] : run_auto_code; // R15 R16
            err_led_code <= err_ovr[OVR_EN_BIT] ? err_ovr[3:0] : err_auto_code; // R16
        end
    end

    // --------------------------------------------------------------
    // Interface select and configuration
    // --------------------------------------------------------------
    // Unimplemented interface codes load as none
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ifsel <= RST_IFSEL; // R20
        end else if (ce) begin
            if (cfg_load) begin
                ifsel <= (cfg_ifsel == IFSEL_SERIAL) ? IFSEL_SERIAL : IFSEL_NONE; // R20
            end
        end
    end

    // Configuration: loaded whole, network may change emulation bit only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg <= RST_CFG;
        end else if (ce) begin
            if (cfg_load) begin
                cfg <= cfg_bits;
            end else if (net_wr && (net_addr == ADDR_CFG)) begin
                cfg[CFG_EMUL_BIT] <= net_wdata[CFG_EMUL_BIT]; // R21
            end
        end
    end

    // Per-port enhanced link enable, all-ports bit overrides
    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_enh
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    enh_link_en[p] <= 1'b0;
                end else if (ce) begin
                    enh_link_en[p] <= cfg[CFG_ENH_ALL_BIT] || cfg[CFG_ENH_PORT_LSB + p]; // R22
                end
            end
        end
    endgenerate

    // Unit power enables and emulation flag
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_out_en <= 1'b0;
            latch_in_en <= 1'b0;
            emulation_on <= 1'b0;
        end else if (ce) begin
            sync_out_en <= cfg[CFG_SYNC_BIT]; // R23
            latch_in_en <= cfg[CFG_LATCH_BIT]; // R23
            emulation_on <= cfg[CFG_EMUL_BIT];
        end
    end

    // --------------------------------------------------------------
    // Read data
    // --------------------------------------------------------------
    // Shared map for both sides; unmapped bytes read zero
    function automatic logic [7:0] read_map(input logic [11:0] a);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            ADDR_STATE_REQ_LO: d = {3'h0, state_req};
            ADDR_STATE_REP_LO: d = {2'h0, state_rep};
            ADDR_CODE_LO: d = status_code[7:0];
            ADDR_CODE_HI: d = status_code[15:8];
            ADDR_RUN_OVR: d = {3'h0, run_ovr[OVR_EN_BIT], run_led_code}; // R18
            ADDR_ERR_OVR: d = {3'h0, err_ovr[OVR_EN_BIT], err_led_code}; // R18
            ADDR_IFSEL: d = ifsel;
            ADDR_CFG: d = cfg;
            default: d = 8'h00;
        endcase
        return d;
    endfunction

    // Read data valid the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            net_rdata <= 8'h00;
            host_rdata <= 8'h00;
        end else if (ce) begin
            if (net_rd) begin
                net_rdata <= read_map(net_addr);
            end
            if (host_rd) begin
                host_rdata <= read_map(host_addr);
            end
        end
    end

endmodule
`default_nettype wire

// ===== shared/app_layer_state_pkg.sv
// Constants and encodings of the application-layer register group
package app_layer_state_pkg;

    // --------------------------------------------------------------
    // Byte addresses
    // --------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_STATE_REQ_LO = 12'h120;
    localparam logic [11:0] ADDR_STATE_REQ_HI = 12'h121;
    localparam logic [11:0] ADDR_STATE_REP_LO = 12'h130;
    localparam logic [11:0] ADDR_STATE_REP_HI = 12'h131;
    localparam logic [11:0] ADDR_CODE_LO = 12'h134;
    localparam logic [11:0] ADDR_CODE_HI = 12'h135;
    localparam logic [11:0] ADDR_RUN_OVR = 12'h138;
    localparam logic [11:0] ADDR_ERR_OVR = 12'h139;
    localparam logic [11:0] ADDR_IFSEL = 12'h140;
    localparam logic [11:0] ADDR_CFG = 12'h141;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int STATE_MSB = 3;
    localparam int ERR_IND_BIT = 4;
    localparam int IDENT_REQ_BIT = 4;
    localparam int IDENT_VALID_BIT = 5;
    localparam int OVR_EN_BIT = 4;
    localparam int CFG_EMUL_BIT = 0;
    localparam int CFG_ENH_ALL_BIT = 1;
    localparam int CFG_SYNC_BIT = 2;
    localparam int CFG_LATCH_BIT = 3;
    localparam int CFG_ENH_PORT_LSB = 4;
    localparam int NUM_PORTS = 4;

    // --------------------------------------------------------------
    // Device state codes and indicator codes
    // --------------------------------------------------------------
    localparam logic [3:0] ST_INIT = 4'h1;
    localparam logic [3:0] ST_PRE_OP = 4'h2;
    localparam logic [3:0] ST_BOOT = 4'h3;
    localparam logic [3:0] ST_SAFE_OP = 4'h4;
    localparam logic [3:0] ST_OP = 4'h8;
    localparam logic [3:0] LED_OFF = 4'h0;
    localparam logic [3:0] LED_FLASH_ONCE = 4'h1;
    localparam logic [3:0] LED_BLINK = 4'hD;
    localparam logic [3:0] LED_FLICKER = 4'hE;
    localparam logic [3:0] LED_ON = 4'hF;

    // --------------------------------------------------------------
    // Interface select codes and reset values
    // --------------------------------------------------------------
    localparam logic [7:0] IFSEL_NONE = 8'h00;
    localparam logic [7:0] IFSEL_SERIAL = 8'h05;
    localparam logic [7:0] IFSEL_ONCHIP = 8'h80;
    localparam logic [4:0] RST_STATE_REQ = 5'h00;
    localparam logic [5:0] RST_STATE_REP = 6'h01;
    localparam logic [15:0] RST_STATUS_CODE = 16'h0000;
    localparam logic [4:0] RST_OVR = 5'h00;
    localparam logic [7:0] RST_IFSEL = 8'h00;
    localparam logic [7:0] RST_CFG = 8'h00;

    // Mailbox occupancy
    typedef enum logic [1:0] {
        MBOX_EMPTY = 2'b01,
        MBOX_FULL = 2'b10
    } mbox_state_t;

endpackage
